// [pced_defs.vh]
`ifndef PCED_DEFS_VH
`define PCED_DEFS_VH

// ****************************************************************
// Register byte offsets on the AHB-Lite slave
// ****************************************************************
`define PCED_OFF_A_RISE   12'h000
`define PCED_OFF_A_FALL   12'h004
`define PCED_OFF_A_FLAG   12'h008
`define PCED_OFF_B_RISE   12'h00C
`define PCED_OFF_B_FALL   12'h010
`define PCED_OFF_B_FLAG   12'h014
`define PCED_OFF_C_RISE   12'h018
`define PCED_OFF_C_FALL   12'h01C
`define PCED_OFF_C_FLAG   12'h020
`define PCED_OFF_CTRL     12'h024
`define PCED_OFF_IRQ_STAT 12'h028
`define PCED_OFF_IRQ_MASK 12'h02C

// ****************************************************************
// Implemented bit masks per port
// ****************************************************************
`define PCED_MASK_A       8'h3F
`define PCED_MASK_B       8'hF0
`define PCED_MASK_C_LARGE 8'hFF
`define PCED_MASK_C_SMALL 8'h3F

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define PCED_CTRL_IRQ_FLAG 0
`define PCED_CTRL_IRQ_EN   1
`define PCED_STAT_PORTA    0
`define PCED_STAT_PORTB    1
`define PCED_STAT_PORTC    2
`define PCED_RST_BYTE      8'h00
`define PCED_RST_STAT      3'h0

// ****************************************************************
// AHB-Lite encodings
// ****************************************************************
`define PCED_HTRANS_NONSEQ 2'h2
`define PCED_HSIZE_WORD    3'h2

`endif

// [pced_sync.v]
`default_nettype none

// ****************************************************************
// Two-stage synchroniser with previous-value register
// ****************************************************************
module pced_sync #(
  parameter WIDTH = 8
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync,
  output wire [WIDTH-1:0] o_prev
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  reg [WIDTH-1:0] prev_r;

  // First stage is read only by the second, avoiding metastable decode
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
      prev_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign o_sync = sync_r;
  assign o_prev = prev_r;

endmodule // pced_sync

`default_nettype wire

// [pced_top.v]
// Behaviour
// R01 - A pin whose fall enable is 1 is watched for high-to-low changes, each one a change event.
// R02 - A pin with both rise and fall enables 0 produces no change events.
// R03 - Each enabled edge sets the pin's change flag and the shared change interrupt flag.
// R04 - A pin's change flag is set when its rise enable is 1 and the pin goes low to high.
// R05 - A pin's change flag is set when its fall enable is 1 and the pin goes high to low.
// R06 - A change flag stays set until software writes 0 to it, which clears it.
// R07 - All enable and flag bits reset to 0 at every reset.
// R08 - Unimplemented bits, including port C bits 7:6 on the small variant, ignore writes and read 0.
// R09 - An enabled edge arriving during a clearing write leaves its flag set whatever was written.
// R10 - With the change interrupt enable set, a change event raises the wake output, flags already updated.
// R11 - Each pin is synchronised and compared with its previous sampled value to find edges.
`include "pced_defs.vh"
`default_nettype none

module pced_top #(
  parameter LARGE_VARIANT = 1
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  input wire [7:0] i_porta_pin,
  input wire [7:0] i_portb_pin,
  input wire [7:0] i_portc_pin,
  output reg o_wake,
  output reg o_irq
);

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam [7:0] MASK_A = `PCED_MASK_A;
  localparam [7:0] MASK_B = `PCED_MASK_B;
  localparam [7:0] MASK_C = (LARGE_VARIANT != 0) ? `PCED_MASK_C_LARGE : `PCED_MASK_C_SMALL;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg [7:0] porta_rise_enable_r;
  reg [7:0] porta_fall_enable_r;
  reg [7:0] porta_change_flag_r;
  reg [7:0] portb_rise_enable_r;
  reg [7:0] portb_fall_enable_r;
  reg [7:0] portb_change_flag_r;
  reg [7:0] portc_rise_enable_r;
  reg [7:0] portc_fall_enable_r;
  reg [7:0] portc_change_flag_r;
  reg change_irq_flag_r;
  reg change_irq_enable_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_mask_r;
  reg [7:0] porta_change_flag_nxt;
  reg [7:0] portb_change_flag_nxt;
  reg [7:0] portc_change_flag_nxt;
  reg change_irq_flag_nxt;
  reg [2:0] irq_stat_nxt;
  reg dp_write_r;
  reg [11:0] dp_addr_r;
  reg [31:0] rdata_nxt;
  wire [7:0] a_sync;
  wire [7:0] a_prev;
  wire [7:0] b_sync;
  wire [7:0] b_prev;
  wire [7:0] c_sync;
  wire [7:0] c_prev;
  wire [7:0] a_evt;
  wire [7:0] b_evt;
  wire [7:0] c_evt;
  wire any_evt;
  wire ap_valid;
  wire [7:0] wbyte;
  wire wr_a_flag;
  wire wr_b_flag;
  wire wr_c_flag;
  wire wr_ctrl;
  wire wr_mask;
  wire rd_stat;
  wire [2:0] port_evt;

  // Edge event: rising with rise enable, or falling with fall enable
  function [7:0] edge_evt;
    input [7:0] cur;
    input [7:0] prv;
    input [7:0] rise_en;
    input [7:0] fall_en;
    input [7:0] impl;
    begin
      edge_evt = ((cur & ~prv & rise_en) | (~cur & prv & fall_en)) & impl; // R01 R02 R04 R05
    end
  endfunction

  // Flag update: a 0 written clears, a fresh event sets and wins
  function [7:0] flag_upd;
    input [7:0] cur;
    input [7:0] evt;
    input wr;
    input [7:0] data;
    input [7:0] impl;
    begin
      flag_upd = (((wr ? (cur & data) : cur)) | evt) & impl; // R06 R09
    end
  endfunction

  // Register hit: a qualified access strobe aimed at one word offset;
  // only the low address bits decode, so the map aliases above them
  function reg_hit;
    input strobe;
    input [11:0] addr;
    input [11:0] offs;
    begin
      reg_hit = strobe && (addr == offs);
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  pced_sync #(.WIDTH(8)) u_sync_a (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_porta_pin),
    .o_sync(a_sync),
    .o_prev(a_prev)
  ); // R11

  pced_sync #(.WIDTH(8)) u_sync_b (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_portb_pin),
    .o_sync(b_sync),
    .o_prev(b_prev)
  ); // R11

  pced_sync #(.WIDTH(8)) u_sync_c (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_portc_pin),
    .o_sync(c_sync),
    .o_prev(c_prev)
  ); // R11

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  // The first cycle after reset compares two reset zeros, so a pin
  // already high at reset shows one rising edge once sampled
  assign a_evt = edge_evt(a_sync, a_prev, porta_rise_enable_r, porta_fall_enable_r, MASK_A);
  assign b_evt = edge_evt(b_sync, b_prev, portb_rise_enable_r, portb_fall_enable_r, MASK_B);
  assign c_evt = edge_evt(c_sync, c_prev, portc_rise_enable_r, portc_fall_enable_r, MASK_C);
  assign any_evt = |{a_evt, b_evt, c_evt};

  // ****************************************************************
  // AHB-Lite address phase capture
  // ****************************************************************
  assign ap_valid = i_hsel & i_hready & i_htrans[1];
  assign wbyte = i_hwdata[7:0];

  // Slave is always ready with OKAY, so data phase lasts one cycle;
  // the transfer size is not checked, every register being one word
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dp_write_r <= 1'b0;
      dp_addr_r <= 12'h000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      dp_write_r <= ap_valid & i_hwrite;
      dp_addr_r <= ap_valid ? i_haddr[11:0] : dp_addr_r;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  // ****************************************************************
  // Register access strobes
  // ****************************************************************
  // Writes land in the data phase, when their byte stands on the bus
  assign wr_a_flag = reg_hit(dp_write_r, dp_addr_r, `PCED_OFF_A_FLAG);
  assign wr_b_flag = reg_hit(dp_write_r, dp_addr_r, `PCED_OFF_B_FLAG);
  assign wr_c_flag = reg_hit(dp_write_r, dp_addr_r, `PCED_OFF_C_FLAG);
  assign wr_ctrl = reg_hit(dp_write_r, dp_addr_r, `PCED_OFF_CTRL);
  assign wr_mask = reg_hit(dp_write_r, dp_addr_r, `PCED_OFF_IRQ_MASK);
  // The status read clears on its address edge, the same edge that
  // captures the read data; clearing a cycle later would drop an event
  // that lands between the capture and the clear
  assign rd_stat = reg_hit(ap_valid & ~i_hwrite, i_haddr[11:0], `PCED_OFF_IRQ_STAT);
  // One status bit per port, set by any enabled edge on that port
  assign port_evt = {|c_evt, |b_evt, |a_evt};

  // ****************************************************************
  // Flag and status next values
  // ****************************************************************
  always @* begin
    porta_change_flag_nxt = flag_upd(porta_change_flag_r, a_evt, wr_a_flag, wbyte, MASK_A); // R03
    portb_change_flag_nxt = flag_upd(portb_change_flag_r, b_evt, wr_b_flag, wbyte, MASK_B); // R03
    portc_change_flag_nxt = flag_upd(portc_change_flag_r, c_evt, wr_c_flag, wbyte, MASK_C); // R03
    // Shared flag: software may write it, but an event wins
    change_irq_flag_nxt = change_irq_flag_r;
    if (wr_ctrl) begin
      change_irq_flag_nxt = wbyte[`PCED_CTRL_IRQ_FLAG];
    end
    change_irq_flag_nxt = change_irq_flag_nxt | any_evt; // R03 R09
    // Sticky status: a read clears, a same-cycle event still sets
    irq_stat_nxt = irq_stat_r;
    if (rd_stat) begin
      irq_stat_nxt = `PCED_RST_STAT;
    end
    irq_stat_nxt = irq_stat_nxt | port_evt;
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Edge enables; masking on write keeps unimplemented bits at zero
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      porta_rise_enable_r <= `PCED_RST_BYTE; // R07
      porta_fall_enable_r <= `PCED_RST_BYTE; // R07
      portb_rise_enable_r <= `PCED_RST_BYTE; // R07
      portb_fall_enable_r <= `PCED_RST_BYTE; // R07
      portc_rise_enable_r <= `PCED_RST_BYTE; // R07
      portc_fall_enable_r <= `PCED_RST_BYTE; // R07
    end else if (dp_write_r) begin
      case (dp_addr_r)
        `PCED_OFF_A_RISE: porta_rise_enable_r <= wbyte & MASK_A; // R08
        `PCED_OFF_A_FALL: porta_fall_enable_r <= wbyte & MASK_A; // R08
        `PCED_OFF_B_RISE: portb_rise_enable_r <= wbyte & MASK_B; // R08
        `PCED_OFF_B_FALL: portb_fall_enable_r <= wbyte & MASK_B; // R08
        `PCED_OFF_C_RISE: portc_rise_enable_r <= wbyte & MASK_C; // R08
        `PCED_OFF_C_FALL: portc_fall_enable_r <= wbyte & MASK_C; // R08
        default: begin
        end
      endcase
    end
  end

  // Change flags take their next value every cycle, since hardware
  // sets them whether or not the bus is busy
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      porta_change_flag_r <= `PCED_RST_BYTE; // R07
      portb_change_flag_r <= `PCED_RST_BYTE; // R07
      portc_change_flag_r <= `PCED_RST_BYTE; // R07
    end else begin
      porta_change_flag_r <= porta_change_flag_nxt;
      portb_change_flag_r <= portb_change_flag_nxt;
      portc_change_flag_r <= portc_change_flag_nxt;
    end
  end

  // Control and interrupt status; the enable and the mask are plain
  // read-write bits, the two flags follow their next values
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      change_irq_flag_r <= 1'b0; // R07
      change_irq_enable_r <= 1'b0; // R07
      irq_stat_r <= `PCED_RST_STAT;
      irq_mask_r <= `PCED_RST_STAT;
    end else begin
      change_irq_flag_r <= change_irq_flag_nxt;
      irq_stat_r <= irq_stat_nxt;
      if (wr_ctrl) begin
        change_irq_enable_r <= wbyte[`PCED_CTRL_IRQ_EN];
      end
      if (wr_mask) begin
        irq_mask_r <= wbyte[2:0];
      end
    end
  end

  // ****************************************************************
  // Read data mux
  // ****************************************************************
  // Unmapped offsets read zero with an OKAY response
  always @* begin
    rdata_nxt = 32'h00000000;
    case (i_haddr[11:0])
      `PCED_OFF_A_RISE: rdata_nxt[7:0] = porta_rise_enable_r;
      `PCED_OFF_A_FALL: rdata_nxt[7:0] = porta_fall_enable_r;
      `PCED_OFF_A_FLAG: rdata_nxt[7:0] = porta_change_flag_r;
      `PCED_OFF_B_RISE: rdata_nxt[7:0] = portb_rise_enable_r;
      `PCED_OFF_B_FALL: rdata_nxt[7:0] = portb_fall_enable_r;
      `PCED_OFF_B_FLAG: rdata_nxt[7:0] = portb_change_flag_r;
      `PCED_OFF_C_RISE: rdata_nxt[7:0] = portc_rise_enable_r;
      `PCED_OFF_C_FALL: rdata_nxt[7:0] = portc_fall_enable_r;
      `PCED_OFF_C_FLAG: rdata_nxt[7:0] = portc_change_flag_r;
      `PCED_OFF_CTRL: begin
        rdata_nxt[`PCED_CTRL_IRQ_FLAG] = change_irq_flag_r;
        rdata_nxt[`PCED_CTRL_IRQ_EN] = change_irq_enable_r;
      end
      `PCED_OFF_IRQ_STAT: rdata_nxt[2:0] = irq_stat_r;
      `PCED_OFF_IRQ_MASK: rdata_nxt[2:0] = irq_mask_r;
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // Read data registered at the address phase, so it is stable in data phase;
  // a read straight after a write to the same register sees the old value,
  // so software leaves one idle cycle or reads back later
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_hrdata <= 32'h00000000;
    end else if (ap_valid && !i_hwrite) begin
      o_hrdata <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Wake and interrupt outputs
  // ****************************************************************
  // Wake follows the shared flag, which is set in the same edge as the pin flags
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= change_irq_enable_r & change_irq_flag_nxt; // R10
    end
  end

  // Level interrupt from the next status, so it drops on the clearing edge
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_nxt & irq_mask_r);
    end
  end

endmodule // pced_top

`default_nettype wire

// [pced_top_monitor.sv]
`include "pced_defs.vh"
`default_nettype none

module pced_monitor #(
  parameter LARGE_VARIANT = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [7:0] i_porta_pin,
  input wire logic [7:0] i_portb_pin,
  input wire logic [7:0] i_portc_pin,
  input wire logic o_wake,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic [23:0] pins_r;
  logic [3:0] pin_age_r;
  logic [3:0] bus_age_r;
  wire [23:0] pins = {i_porta_pin, i_portb_pin, i_portc_pin};
  wire [11:0] offs = i_haddr[11:0];
  wire take = i_hsel & i_hready & i_htrans[1];
  wire rd = take & ~i_hwrite;
  wire six = (offs < 12'h00C) || (LARGE_VARIANT == 0 && offs >= 12'h018 && offs <= 12'h020);
  wire gap = offs >= 12'h00C && offs <= 12'h014;

  // Ages since a pin change or bus transfer; saturate so they never wrap into a false cause
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pins_r <= 24'h000000;
      pin_age_r <= 4'hF;
      bus_age_r <= 4'hF;
    end else begin
      pins_r <= pins;
      pin_age_r <= (pins != pins_r) ? 4'h0 : pin_age_r + {3'h0, pin_age_r != 4'hF};
      bus_age_r <= take ? 4'h0 : bus_age_r + {3'h0, bus_age_r != 4'hF};
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  resp_okay_a: assert property (rd |=> !o_hresp && o_hreadyout)
    else $error("Read data phase not ready and OKAY");
  upper_zero_a: assert property (rd |=> o_hrdata[31:8] == 24'h000000)
    else $error("Read data above bit 7 not zero");
  top_pair_a: assert property (rd && six |=> o_hrdata[7:6] == 2'b00)
    else $error("Absent top bits read nonzero");
  low_nibble_a: assert property (rd && gap |=> o_hrdata[3:0] == 4'h0)
    else $error("Port B low bits read nonzero");
  unmapped_a: assert property (rd && offs > `PCED_OFF_IRQ_MASK |=> o_hrdata == 32'h00000000)
    else $error("Unmapped read nonzero");
  reset_quiet_a: assert property ($rose(i_rst_b) |-> !o_irq && !o_wake)
    else $error("Interrupt outputs high after reset");
  irq_cause_a: assert property ($rose(o_irq) |-> pin_age_r <= 4'd6 || bus_age_r <= 4'd3)
    else $error("Interrupt rose without a cause");
  wake_cause_a: assert property ($rose(o_wake) |-> pin_age_r <= 4'd6 || bus_age_r <= 4'd3)
    else $error("Wake rose without a cause");
  irq_sticky_a: assert property ($fell(o_irq) |-> bus_age_r <= 4'd3)
    else $error("Interrupt dropped without software");
  wake_sticky_a: assert property ($fell(o_wake) |-> bus_age_r <= 4'd3)
    else $error("Wake dropped without software");

  cover property ($rose(o_irq));
  cover property ($rose(o_wake));
  cover property (rd && offs == `PCED_OFF_IRQ_STAT);
endmodule // pced_monitor

bind pced_top pced_monitor #(.LARGE_VARIANT(LARGE_VARIANT)) i_pced_monitor (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_porta_pin(i_porta_pin), .i_portb_pin(i_portb_pin),
  .i_portc_pin(i_portc_pin), .o_wake(o_wake), .o_irq(o_irq)
);
`default_nettype wire

// [tb_pin_change_edge_detector.sv]
`include "pced_defs.vh"
`default_nettype none

module tb_pin_change_edge_detector;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [2:0] i_hsize = 3'h0;
  logic [31:0] i_hwdata = 32'h0;
  logic [7:0] i_porta_pin = 8'h00;
  logic [7:0] i_portb_pin = 8'h00;
  logic [7:0] i_portc_pin = 8'h00;
  wire [31:0] o_hrdata;
  wire o_hreadyout;
  wire o_hresp;
  wire o_wake;
  wire o_irq;
  wire [31:0] o_hrdata_l;
  wire o_hreadyout_l;
  wire o_hresp_l;
  wire o_wake_l;
  wire o_irq_l;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] rdata;
  logic [31:0] rdata_l;
  logic [11:0] offs [8] = '{12'h000, 12'h004, 12'h00C, 12'h010, 12'h018, 12'h01C, 12'h02C, 12'h030};
  logic [7:0] ffv [8] = '{8'h3F, 8'h3F, 8'hF0, 8'hF0, 8'h3F, 8'h3F, 8'h07, 8'h00};

  // Small variant, so port C bits 7:6 must stay absent
  pced_top #(.LARGE_VARIANT(0)) i_pced_top (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_porta_pin(i_porta_pin),
    .i_portb_pin(i_portb_pin), .i_portc_pin(i_portc_pin), .o_wake(o_wake), .o_irq(o_irq)
  );

  // Large variant on the same bus, so port C bits 7:6 are seen implemented
  pced_top #(.LARGE_VARIANT(1)) i_pced_top_large (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata_l), .o_hreadyout(o_hreadyout_l), .o_hresp(o_hresp_l), .i_porta_pin(i_porta_pin),
    .i_portb_pin(i_portb_pin), .i_portc_pin(i_portc_pin), .o_wake(o_wake_l), .o_irq(o_irq_l)
  );

  always #2 i_sys_clk = ~i_sys_clk;

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Single word transfer; waits on ready, never on a fixed count
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_hsel <= 1'b1;
    i_htrans <= `PCED_HTRANS_NONSEQ;
    i_haddr <= {20'h0, a};
    i_hwrite <= wr;
    i_hsize <= `PCED_HSIZE_WORD;
    do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hsel <= 1'b0;
    i_hwdata <= {24'h0, d};
    do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
    rdata = o_hrdata;
    rdata_l = o_hrdata_l;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 8'h00);
    chk(rdata, exp);
  endtask

  task automatic end_sim;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  // Run needs about 210 cycles; the limit leaves wide margin
  initial begin
    #20000;
    errors++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    for (int i = 0; i < 12; i++) rd_chk(12'(4 * i), 32'h0);
    // Only implemented bits keep a written one
    for (int i = 0; i < 8; i++) begin
      wr(offs[i], 8'hFF);
      rd_chk(offs[i], {24'h0, ffv[i]});
      if (i == 4 || i == 5) chk(rdata_l, 32'h000000FF);
      wr(offs[i], 8'h00);
    end
    wr(`PCED_OFF_A_RISE, 8'h01);
    wr(`PCED_OFF_A_FALL, 8'h02);
    wr(`PCED_OFF_CTRL, 8'h02);
    wr(`PCED_OFF_IRQ_MASK, 8'h01);
    // Pin 0 rises enabled, pin 1 rises fall-only, pin 2 has no enables
    @(posedge i_sys_clk);
    i_porta_pin <= 8'h07;
    repeat (5) @(posedge i_sys_clk);
    chk({31'h0, o_wake}, 32'h1);
    chk({31'h0, o_irq}, 32'h1);
    rd_chk(`PCED_OFF_A_FLAG, 32'h01);
    rd_chk(`PCED_OFF_CTRL, 32'h03);
    rd_chk(`PCED_OFF_IRQ_STAT, 32'h01);
    rd_chk(`PCED_OFF_IRQ_STAT, 32'h00);
    chk({31'h0, o_irq}, 32'h0);
    // Pin 1 falls exactly as a clearing write lands
    @(posedge i_sys_clk);
    i_porta_pin <= 8'h05;
    wr(`PCED_OFF_A_FLAG, 8'h00);
    rd_chk(`PCED_OFF_A_FLAG, 32'h02);
    wr(`PCED_OFF_A_FLAG, 8'h02);
    rd_chk(`PCED_OFF_A_FLAG, 32'h02);
    wr(`PCED_OFF_A_FLAG, 8'h00);
    rd_chk(`PCED_OFF_A_FLAG, 32'h00);
    rd_chk(`PCED_OFF_IRQ_STAT, 32'h01);
    wr(`PCED_OFF_CTRL, 8'h02);
    rd_chk(`PCED_OFF_CTRL, 32'h02);
    chk({31'h0, o_wake}, 32'h0);
    // Port B rises, port C rises unenabled then falls enabled
    wr(`PCED_OFF_B_RISE, 8'hFF);
    wr(`PCED_OFF_C_FALL, 8'hFF);
    @(posedge i_sys_clk);
    i_portb_pin <= 8'hFF;
    i_portc_pin <= 8'hFF;
    repeat (5) @(posedge i_sys_clk);
    i_portc_pin <= 8'h00;
    repeat (5) @(posedge i_sys_clk);
    chk({31'h0, o_irq}, 32'h0);
    wr(`PCED_OFF_IRQ_MASK, 8'h07);
    rd_chk(`PCED_OFF_B_FLAG, 32'hF0);
    chk({31'h0, o_irq}, 32'h1);
    rd_chk(`PCED_OFF_C_FLAG, 32'h3F);
    chk(rdata_l, 32'h000000FF);
    rd_chk(`PCED_OFF_IRQ_STAT, 32'h06);
    // Second reset in mid-run clears everything again
    @(posedge i_sys_clk);
    i_rst_b <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    rd_chk(`PCED_OFF_B_RISE, 32'h0);
    rd_chk(`PCED_OFF_B_FLAG, 32'h0);
    rd_chk(`PCED_OFF_CTRL, 32'h0);
    chk({31'h0, o_wake}, 32'h0);
    end_sim();
  end
endmodule // tb_pin_change_edge_detector
`default_nettype wire
